/* File: src/char_lcd_instruction_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module char_lcd_instruction_engine
  import lcd_pkg::*;
#(
  parameter int unsigned LONG_CYCLES = LONG_CYC, // clear/home busy
  parameter int unsigned BLINK_CYCLES = BLINK_CYC // blink half period
) (
  input wire logic core_clk, // core clock
  input wire logic srst, // sync reset
  input wire logic e_pin, // parallel strobe
  input wire logic register_select, // 0 instruction, 1 data
  input wire logic read_write, // 1 read
  input wire logic [7:0] db_in, // data bus in
  output logic [7:0] db_out, // data bus out
  output logic db_oe, // data bus drive enable
  input wire logic serial_chip_select_n, // spi select
  input wire logic serial_in, // spi data
  input wire logic serial_clk, // spi clock
  input wire logic host_port_strap_hi, // port strap
  input wire logic host_port_strap_lo, // port strap
  input wire logic [6:0] scan_col, // column on screen
  input wire logic scan_line, // screen line
  output logic [7:0] scan_code, // char code at scan cell
  output logic scan_solid, // cell shown all lit
  output logic scan_cursor, // cursor at scan cell
  output logic scan_blank, // panel blanked
  output logic busy_flag, // busy
  output logic [6:0] address_counter, // address counter
  output logic bus_width_select, // 1: 8-bit bus
  output duty_e duty, // multiplex duty
  output disp_ctl_s display_ctl, // panel, cursor, blink
  output logic [6:0] shift_offset // display shift
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] char_mem [CHAR_DEPTH];
  logic [7:0] glyph_mem [GLYPH_DEPTH];
  eng_state_e state_q;
  logic [6:0] clr_idx_q;
  logic [BUSY_W-1:0] busy_cnt_q;
  logic [6:0] ac_q;
  logic [6:0] shift_q;
  logic glyph_sel_q;
  logic entry_inc_q;
  logic entry_shift_q;
  logic width_q;
  logic two_line_q;
  logic font_q;
  disp_ctl_s disp_q;
  logic reload_q;
  logic [7:0] read_buf_q;
  logic [7:0] status_q;
  logic busy_q;
  logic blink_phase;
  logic req_valid;
  host_req_s req;

  // ---------------------------------------------------------------
  // host port and blink timer
  // ---------------------------------------------------------------
  host_port u_port (
    .core_clk(core_clk),
    .srst(srst),
    .e_pin(e_pin),
    .register_select(register_select),
    .read_write(read_write),
    .db_in(db_in),
    .serial_chip_select_n(serial_chip_select_n),
    .serial_in(serial_in),
    .serial_clk(serial_clk),
    .host_port_strap_hi(host_port_strap_hi),
    .host_port_strap_lo(host_port_strap_lo),
    .width_8(width_q),
    .status_byte(status_q),
    .data_byte(read_buf_q),
    .db_out_q(db_out),
    .db_oe_q(db_oe),
    .req_valid_q(req_valid),
    .req_q(req)
  );

  blink_timer #(
    .HALF_CYC(BLINK_CYCLES)
  ) u_blink (
    .core_clk(core_clk),
    .srst(srst),
    .enable(disp_q.blink_on),
    .phase_q(blink_phase)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic accept, wr_instr, wr_data, rd_data;
  logic do_clear, do_home, do_entry, do_disp, do_shift, do_func;
  logic do_glyph, do_char, cur_shift, disp_shift, wr_shift;
  logic [6:0] line_len;

  // busy refuses everything but status reads, which the port answers
  assign accept = req_valid && !busy_q && (req.rs || !req.rw);
  assign wr_instr = accept && !req.rs && !req.rw;
  assign wr_data = accept && req.rs && !req.rw;
  assign rd_data = accept && req.rs && req.rw;

  always_comb begin
    do_clear = 1'b0;
    do_home = 1'b0;
    do_entry = 1'b0;
    do_disp = 1'b0;
    do_shift = 1'b0;
    do_func = 1'b0;
    do_glyph = 1'b0;
    do_char = 1'b0;
    if (wr_instr) begin
      casez (req.data)
        8'b1???_????: do_char = 1'b1;
        8'b01??_????: do_glyph = 1'b1;
        8'b001?_????: do_func = 1'b1;
        8'b0001_????: do_shift = 1'b1;
        8'b0000_1???: do_disp = 1'b1;
        8'b0000_01??: do_entry = 1'b1;
        8'b0000_001?: do_home = 1'b1;
        8'b0000_0001: do_clear = 1'b1;
        default: ;
      endcase
    end
  end

  assign cur_shift = do_shift && !req.data[SHIFT_DISP_BIT];
  assign disp_shift = do_shift && req.data[SHIFT_DISP_BIT];
  assign wr_shift = wr_data && !glyph_sel_q && entry_shift_q;
  assign line_len = two_line_q ? LINE_LEN_TWO : LINE_LEN_ONE;

  // next char address with line wrap
  function automatic logic [6:0] step_char(input logic [6:0] a,
                                           input logic up,
                                           input logic two);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (two) begin
      if (up && a == LINE1_LAST) r = LINE2_FIRST;
      else if (up && a == LINE2_LAST) r = LINE1_FIRST;
      else if (!up && a == LINE2_FIRST) r = LINE1_LAST;
      else if (!up && a == LINE1_FIRST) r = LINE2_LAST;
    end else begin
      if (up && a == ONE_LINE_LAST) r = LINE1_FIRST;
      else if (!up && a == LINE1_FIRST) r = ONE_LINE_LAST;
    end
    return r;
  endfunction : step_char

  function automatic logic [6:0] step_any(input logic [6:0] a,
                                          input logic up,
                                          input logic two,
                                          input logic glyph);
    logic [5:0] g;
    g = up ? a[5:0] + 6'h01 : a[5:0] - 6'h01;
    return glyph ? {1'b0, g} : step_char(a, up, two);
  endfunction : step_any

  // ---------------------------------------------------------------
  // sequencer and busy
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin // power-on clear under busy
      state_q <= ST_CLEAR;
      clr_idx_q <= 7'h00;
      busy_cnt_q <= BUSY_W'(LONG_CYCLES);
    end else begin
      if (state_q == ST_CLEAR) begin
        clr_idx_q <= clr_idx_q + 7'h01;
        if (clr_idx_q == 7'(CHAR_DEPTH - 1)) begin
          state_q <= ST_IDLE;
        end
      end
      if (do_clear) begin
        state_q <= ST_CLEAR;
        clr_idx_q <= 7'h00;
      end
      if (do_clear || do_home) begin
        busy_cnt_q <= BUSY_W'(LONG_CYCLES);
      end else if (accept && !(req.rw && !req.rs)) begin
        busy_cnt_q <= BUSY_W'(EXEC_CYC);
      end else if (busy_cnt_q != '0) begin
        busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_q <= 1'b1;
      status_q <= 8'h80;
    end else begin
      busy_q <= state_q == ST_CLEAR || busy_cnt_q > BUSY_W'(1) || accept;
      status_q <= {busy_q, ac_q};
    end
  end

  // ---------------------------------------------------------------
  // memories
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (state_q == ST_CLEAR) begin
      char_mem[clr_idx_q] <= SPACE_CODE;
    end else if (wr_data && !glyph_sel_q) begin
      char_mem[ac_q] <= req.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_data && glyph_sel_q) begin
      glyph_mem[ac_q[5:0]] <= req.data;
    end
  end

  // ---------------------------------------------------------------
  // address counter and target
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ac_q <= AC_HOME;
      glyph_sel_q <= 1'b0;
    end else if (do_clear || do_home) begin
      ac_q <= AC_HOME;
      glyph_sel_q <= 1'b0;
    end else if (do_char) begin
      ac_q <= req.data[6:0];
      glyph_sel_q <= 1'b0;
    end else if (do_glyph) begin
      ac_q <= {1'b0, req.data[5:0]};
      glyph_sel_q <= 1'b1;
    end else if (cur_shift) begin
      ac_q <= step_any(ac_q, req.data[SHIFT_RIGHT_BIT], two_line_q,
                       glyph_sel_q);
    end else if (wr_data || rd_data) begin
      ac_q <= step_any(ac_q, entry_inc_q, two_line_q, glyph_sel_q);
    end
  end

  // ---------------------------------------------------------------
  // display shift, counter stays put on the shift instruction but steps on a shifting data write
  // ---------------------------------------------------------------
  logic shift_left, shift_right;
  assign shift_left = (disp_shift && !req.data[SHIFT_RIGHT_BIT]) ||
                      (wr_shift && entry_inc_q);
  assign shift_right = (disp_shift && req.data[SHIFT_RIGHT_BIT]) ||
                       (wr_shift && !entry_inc_q);

  always_ff @(posedge core_clk) begin
    if (srst || do_clear || do_home || do_func) begin
      shift_q <= 7'h00;
    end else if (shift_left) begin
      shift_q <= (shift_q == line_len - 7'h01) ? 7'h00 : shift_q + 7'h01;
    end else if (shift_right) begin
      shift_q <= (shift_q == 7'h00) ? line_len - 7'h01 : shift_q - 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // mode settings
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      entry_inc_q <= RST_ENTRY_INC;
      entry_shift_q <= RST_ENTRY_SHIFT;
      disp_q <= '0;
    end else begin
      if (do_clear) begin
        entry_inc_q <= 1'b1;
      end else if (do_entry) begin
        entry_inc_q <= req.data[ENTRY_INC_BIT];
        entry_shift_q <= req.data[ENTRY_SHIFT_BIT];
      end
      if (do_disp) begin
        disp_q <= '{req.data[DISP_ON_BIT], req.data[CURSOR_ON_BIT],
                    req.data[BLINK_ON_BIT]};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      width_q <= RST_WIDTH_8;
      two_line_q <= RST_TWO_LINE;
      font_q <= RST_FONT_11;
    end else if (do_func) begin
      width_q <= req.data[FUNC_WIDTH_BIT];
      two_line_q <= req.data[FUNC_LINES_BIT];
      font_q <= req.data[FUNC_FONT_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      duty <= DUTY_8;
    end else if (two_line_q) begin
      duty <= DUTY_16; // font ignored
    end else begin
      duty <= font_q ? DUTY_11 : DUTY_8;
    end
  end

  // ---------------------------------------------------------------
  // prefetch register
  // ---------------------------------------------------------------
  // one cycle late so it sees the counter after its update
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reload_q <= 1'b0;
      read_buf_q <= 8'h00;
    end else begin
      reload_q <= do_char || do_glyph || rd_data ||
                  (cur_shift && !glyph_sel_q);
      if (reload_q) begin
        read_buf_q <= glyph_sel_q ? glyph_mem[ac_q[5:0]] : char_mem[ac_q];
      end
    end
  end

  // ---------------------------------------------------------------
  // scan readout
  // ---------------------------------------------------------------
  logic [7:0] pos_sum;
  logic [6:0] pos;
  logic [6:0] scan_addr;
  assign pos_sum = {1'b0, scan_col} + {1'b0, shift_q};
  assign pos = (pos_sum >= {1'b0, line_len}) ?
               7'(pos_sum - {1'b0, line_len}) : pos_sum[6:0];
  assign scan_addr = (two_line_q && scan_line) ? LINE2_FIRST + pos : pos;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      scan_code <= SPACE_CODE;
      scan_solid <= 1'b0;
      scan_cursor <= 1'b0;
      scan_blank <= 1'b1;
    end else begin
      scan_code <= char_mem[scan_addr]; // memory kept while blank
      scan_blank <= !disp_q.panel_on;
      scan_cursor <= disp_q.panel_on && disp_q.cursor_on &&
                     !glyph_sel_q && scan_addr == ac_q;
      scan_solid <= disp_q.panel_on && disp_q.blink_on && blink_phase &&
                    !glyph_sel_q && scan_addr == ac_q;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign busy_flag = busy_q;
  assign address_counter = ac_q;
  assign bus_width_select = width_q;
  assign display_ctl = disp_q;
  assign shift_offset = shift_q;

endmodule : char_lcd_instruction_engine
`default_nettype wire

/* File: inc/lcd_pkg.sv */
package lcd_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned EXEC_TIME_NS = 18_500;
  localparam int unsigned LONG_TIME_NS = 760_000;
  localparam int unsigned BLINK_TIME_NS = 185_000_000;
  // least times round up, the blink interval is nominal
  localparam int unsigned EXEC_CYC =
    (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LONG_CYC =
    (LONG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLINK_CYC = BLINK_TIME_NS / CLK_PERIOD_NS;
  localparam int BUSY_W = 24;
  localparam int BLINK_W = 24;

  // ---------------------------------------------------------------
  // memory map and codes
  // ---------------------------------------------------------------
  localparam int CHAR_DEPTH = 128;
  localparam int GLYPH_DEPTH = 64;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [6:0] AC_HOME = 7'h00;
  localparam logic [6:0] LINE1_FIRST = 7'h00;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_FIRST = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
  localparam logic [6:0] LINE_LEN_TWO = 7'h28;
  localparam logic [6:0] LINE_LEN_ONE = 7'h50;

  // ---------------------------------------------------------------
  // instruction field positions
  // ---------------------------------------------------------------
  localparam int ENTRY_INC_BIT = 1;
  localparam int ENTRY_SHIFT_BIT = 0;
  localparam int DISP_ON_BIT = 2;
  localparam int CURSOR_ON_BIT = 1;
  localparam int BLINK_ON_BIT = 0;
  localparam int SHIFT_DISP_BIT = 3;
  localparam int SHIFT_RIGHT_BIT = 2;
  localparam int FUNC_WIDTH_BIT = 4;
  localparam int FUNC_LINES_BIT = 3;
  localparam int FUNC_FONT_BIT = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_WIDTH_8 = 1'b1;
  localparam logic RST_TWO_LINE = 1'b0;
  localparam logic RST_FONT_11 = 1'b0;
  localparam logic RST_ENTRY_INC = 1'b1;
  localparam logic RST_ENTRY_SHIFT = 1'b0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PORT_PARALLEL = 2'b00,
    PORT_I2C = 2'b01,
    PORT_SPI = 2'b10,
    PORT_NONE = 2'b11
  } host_port_e;

  typedef enum logic [1:0] {
    DUTY_8 = 2'b00,
    DUTY_11 = 2'b01,
    DUTY_16 = 2'b10
  } duty_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CLEAR = 1'b1
  } eng_state_e;

  typedef struct packed {
    logic rs;
    logic rw;
    logic [7:0] data;
  } host_req_s;

  typedef struct packed {
    logic panel_on;
    logic cursor_on;
    logic blink_on;
  } disp_ctl_s;

endpackage : lcd_pkg

/* File: src/blink_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module blink_timer
  import lcd_pkg::*;
#(
  parameter int unsigned HALF_CYC = BLINK_CYC
) (
  input wire logic core_clk, // core clock
  input wire logic srst, // sync reset
  input wire logic enable, // blink on
  output logic phase_q // high: cell shown all lit
);

  logic [BLINK_W-1:0] cnt_q;

  // phase restarts at the stored char whenever blink is off
  always_ff @(posedge core_clk) begin
    if (srst || !enable) begin
      cnt_q <= '0;
      phase_q <= 1'b0;
    end else if (cnt_q == BLINK_W'(HALF_CYC - 1)) begin
      cnt_q <= '0;
      phase_q <= !phase_q;
    end else begin
      cnt_q <= cnt_q + BLINK_W'(1);
    end
  end

endmodule : blink_timer
`default_nettype wire

/* File: src/host_port.sv */
`timescale 1ns/1ps
`default_nettype none
module host_port
  import lcd_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic srst, // sync reset
  input wire logic e_pin, // parallel strobe
  input wire logic register_select, // 0 instruction, 1 data
  input wire logic read_write, // 1 read
  input wire logic [7:0] db_in, // data bus in
  input wire logic serial_chip_select_n, // spi select
  input wire logic serial_in, // spi data
  input wire logic serial_clk, // spi clock
  input wire logic host_port_strap_hi, // strap
  input wire logic host_port_strap_lo, // strap
  input wire logic width_8, // 8-bit parallel mode
  input wire logic [7:0] status_byte, // busy and counter
  input wire logic [7:0] data_byte, // prefetch register
  output logic [7:0] db_out_q, // data bus out
  output logic db_oe_q, // data bus drive enable
  output logic req_valid_q, // one-cycle request
  output host_req_s req_q // request content
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int PIN_W = 16;
  // select and serial clock idle high; a zero reset would fake an edge
  localparam logic [PIN_W-1:0] PIN_IDLE = 16'h0014;
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic [PIN_W-1:0] prev_q;

  assign pins_raw = {e_pin, register_select, read_write, db_in,
    serial_chip_select_n, serial_in, serial_clk,
    host_port_strap_hi, host_port_strap_lo};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_q <= PIN_IDLE;
      sync2_q <= PIN_IDLE;
      prev_q <= PIN_IDLE;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  logic e_s, rs_s, rw_s, csn_s, sin_s, sclk_s, e_fall, sclk_rise;
  logic [7:0] db_s;
  host_port_e port;
  logic [7:0] rd_byte;
  assign e_s = sync2_q[15];
  assign rs_s = sync2_q[14];
  assign rw_s = sync2_q[13];
  assign db_s = sync2_q[12:5];
  assign csn_s = sync2_q[4];
  assign sin_s = sync2_q[3];
  assign sclk_s = sync2_q[2];
  assign port = host_port_e'(sync2_q[1:0]);
  assign e_fall = prev_q[15] && !e_s;
  assign sclk_rise = !prev_q[2] && sclk_s;
  assign rd_byte = rs_s ? data_byte : status_byte;

  // ---------------------------------------------------------------
  // receive
  // ---------------------------------------------------------------
  logic nib_q;
  logic [3:0] hold_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shreg_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      nib_q <= 1'b0;
      hold_q <= 4'h0;
      bit_cnt_q <= 3'h0;
      shreg_q <= 7'h00;
      req_valid_q <= 1'b0;
      req_q <= '0;
    end else begin
      req_valid_q <= 1'b0;
      if (port == PORT_PARALLEL && e_fall) begin
        if (width_8) begin
          req_valid_q <= 1'b1;
          req_q <= '{rs_s, rw_s, db_s};
          nib_q <= 1'b0;
        end else if (!nib_q) begin // high nibble first
          hold_q <= db_s[7:4];
          nib_q <= 1'b1;
        end else begin
          req_valid_q <= 1'b1;
          req_q <= '{rs_s, rw_s, {hold_q, db_s[7:4]}};
          nib_q <= 1'b0;
        end
      end
      // serial is write only, msb first
      if (port == PORT_SPI) begin
        if (csn_s) begin
          bit_cnt_q <= 3'h0;
        end else if (sclk_rise) begin
          shreg_q <= {shreg_q[5:0], sin_s};
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (bit_cnt_q == 3'h7) begin
            req_valid_q <= 1'b1;
            req_q <= '{rs_s, 1'b0, {shreg_q, sin_s}};
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read drive, parallel only
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      db_oe_q <= 1'b0;
      db_out_q <= 8'h00;
    end else begin
      db_oe_q <= (port == PORT_PARALLEL) && e_s && rw_s;
      if (width_8) begin
        db_out_q <= rd_byte;
      end else begin
        db_out_q <= {(nib_q ? rd_byte[3:0] : rd_byte[7:4]), 4'h0};
      end
    end
  end

endmodule : host_port
`default_nettype wire

/* File: tb/char_lcd_instruction_engine_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module char_lcd_instruction_engine_sva
  import lcd_pkg::*;
(
  input wire logic core_clk, // clk
  input wire logic srst, // rst
  input wire logic e_pin, // strobe
  input wire logic read_write, // dir
  input wire logic host_port_strap_hi, // strap
  input wire logic host_port_strap_lo, // strap
  input wire logic db_oe, // drive
  input wire logic scan_blank, // blank
  input wire logic busy_flag, // busy
  input wire logic [6:0] address_counter, // counter
  input wire logic bus_width_select, // width
  input wire duty_e duty, // duty
  input wire disp_ctl_s display_ctl // ctl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence busy_next;
    ##1 busy_flag;
  endsequence
  oe_strap_a: assert property (
    db_oe |-> !host_port_strap_hi && !host_port_strap_lo) else $error("oe");
  oe_read_a: assert property (
    $rose(db_oe) |-> $past(e_pin, 2) && $past(read_write, 2)) else $error("rd");
  panel_blank_a: assert property (
    $changed(display_ctl.panel_on) |->
    ##[0:2] scan_blank == !display_ctl.panel_on) else $error("blank");
  busy_hold_a: assert property (
    $rose(busy_flag) |-> busy_flag[*8]) else $error("busy short");
  ac_busy_a: assert property (
    $changed(address_counter) |-> busy_next) else $error("ac idle");
  width_busy_a: assert property (
    $changed(bus_width_select) |-> busy_next) else $error("width idle");
  duty_busy_a: assert property (
    $changed(duty) |-> busy_next) else $error("duty idle");
  ctl_busy_a: assert property (
    $changed(display_ctl) |-> busy_next) else $error("ctl idle");
endmodule : char_lcd_instruction_engine_sva
bind char_lcd_instruction_engine char_lcd_instruction_engine_sva u_sva (
  .core_clk, .srst, .e_pin, .read_write, .host_port_strap_hi,
  .host_port_strap_lo, .db_oe, .scan_blank, .busy_flag, .address_counter,
  .bus_width_select, .duty, .display_ctl);
`default_nettype wire

/* File: tb/host_mpu.sv */
`timescale 1ns/1ps
`default_nettype none
module host_mpu (
  input wire logic core_clk, // clk
  input wire logic [7:0] db_out, // read bus
  output var logic e_pin = 0, // strobe
  output var logic register_select = 0, // rs
  output var logic read_write = 0, // dir
  output var logic [7:0] db_in = 8'h5A, // bus
  output var logic serial_chip_select_n = 1, // spi select
  output var logic serial_in = 0, // spi data
  output var logic serial_clk = 1 // idles high
);
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : cyc
  // released bus flips so a stale value never reads as valid
  task automatic xfer(input logic s, input logic w, input logic [7:0] d,
    output logic [7:0] q);
    cyc(1);
    register_select = s;
    read_write = w;
    db_in = w ? ~db_in : d;
    e_pin = 1;
    cyc(8);
    q = db_out;
    e_pin = 0;
    cyc(8);
    db_in = ~db_in;
  endtask : xfer
  task automatic wait_ready(output logic ok);
    logic [7:0] st;
    ok = 0;
    for (int i = 0; i < 400 && !ok; i++) begin
      xfer(0, 1, 8'h00, st);
      ok = (st[7] === 1'b0);
    end
  endtask : wait_ready
  task automatic spi(input logic s, input logic [7:0] d);
    serial_chip_select_n = 0;
    register_select = s;
    for (int i = 7; i >= 0; i--) begin
      serial_clk = 0;
      serial_in = d[i];
      cyc(4);
      serial_clk = 1;
      cyc(4);
    end
    serial_chip_select_n = 1;
    serial_in = ~serial_in;
  endtask : spi
endmodule : host_mpu
`default_nettype wire

/* File: tb/char_lcd_instruction_engine_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module char_lcd_instruction_engine_tb_top;
  import lcd_pkg::*;
  logic core_clk = 0, srst = 1, host_port_strap_hi = 0, scan_line = 0;
  logic e_pin, register_select, read_write, serial_chip_select_n;
  logic serial_in, serial_clk, db_oe, scan_solid, scan_cursor, scan_blank;
  logic busy_flag, bus_width_select, host_port_strap_lo = 0;
  logic [6:0] scan_col = 0, address_counter, shift_offset;
  logic [7:0] db_in, db_out, scan_code, q, v;
  duty_e duty;
  disp_ctl_s display_ctl;
  int error_cnt = 0, n_tests = 0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    #2 scan_col = 7'($urandom % 40);
    scan_line = ~scan_line;
  end
  char_lcd_instruction_engine #(.LONG_CYCLES(200), .BLINK_CYCLES(16)) u_dut (
    .core_clk, .srst, .e_pin, .register_select, .read_write, .db_in, .db_out,
    .db_oe, .serial_chip_select_n, .serial_in, .serial_clk,
    .host_port_strap_hi, .host_port_strap_lo, .scan_col, .scan_line,
    .scan_code, .scan_solid, .scan_cursor, .scan_blank, .busy_flag,
    .address_counter, .bus_width_select, .duty, .display_ctl, .shift_offset);
  host_mpu u_host (.core_clk, .db_out, .e_pin, .register_select, .read_write,
    .db_in, .serial_chip_select_n, .serial_in, .serial_clk);
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", what, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic rdy;
    logic ok;
    u_host.wait_ready(ok);
    if (!ok) begin
      error_cnt++;
      end_sim();
    end
  endtask : rdy
  task automatic op(input logic s, input logic w, input logic [7:0] d);
    u_host.xfer(s, w, d, q);
    rdy();
  endtask : op
  initial begin
    static logic [7:0] fs [3] = '{8'h30, 8'h34, 8'h3B};
    v = 8'($urandom(6738));
    repeat (4) @(posedge core_clk);
    #2 srst = 0;
    rdy();
    chk("ac", 8'h00, address_counter);
    chk("width", 8'h01, bus_width_select);
    chk("blank", 8'h01, scan_blank);
    for (int i = 0; i < 3; i++) begin
      op(0, 0, fs[i]);
      chk("duty", 8'(i), duty);
    end
    op(0, 0, 8'h0F);
    chk("ctl", 8'h07, display_ctl);
    chk("blank", 8'h00, scan_blank);
    op(0, 0, 8'hA7);
    op(1, 0, v);
    chk("ac", 8'h40, address_counter);
    op(0, 0, 8'hA7);
    op(1, 1, 8'h00);
    chk("data", v, q);
    op(0, 0, 8'hC5);
    op(0, 0, 8'h04);
    op(1, 0, v);
    chk("ac", 8'h44, address_counter);
    op(0, 0, 8'h13);
    chk("ac", 8'h43, address_counter);
    op(0, 0, 8'h18);
    chk("ac", 8'h43, address_counter);
    chk("shift", 8'h01, shift_offset);
    op(0, 0, 8'h07);
    op(1, 0, v);
    chk("shift", 8'h02, shift_offset);
    op(0, 0, 8'h03);
    chk("ac", 8'h00, address_counter);
    chk("shift", 8'h00, shift_offset);
    op(0, 0, 8'h04);
    op(0, 0, 8'h01);
    op(0, 0, 8'hA7);
    op(1, 1, 8'h00);
    chk("data", 8'h20, q);
    chk("ac", 8'h40, address_counter);
    u_host.xfer(0, 1, 8'h00, q);
    chk("status", 8'h40, q);
    op(0, 0, 8'h45);
    op(1, 0, v);
    op(0, 0, 8'h45);
    op(1, 1, 8'h00);
    chk("glyph", v, q);
    chk("ac", 8'h06, address_counter);
    op(0, 0, 8'h80);
    op(1, 0, 8'hC3);
    op(0, 0, 8'h10);
    op(1, 1, 8'h00);
    chk("data", 8'hC3, q);
    u_host.xfer(0, 0, 8'h28, q);
    u_host.cyc(800);
    u_host.xfer(0, 0, 8'h8F, q);
    chk("ac", 8'h01, address_counter);
    chk("busy", 8'h00, busy_flag);
    u_host.xfer(0, 0, 8'h5F, q);
    u_host.cyc(800);
    chk("ac", 8'h05, address_counter);
    u_host.xfer(0, 0, 8'h30, q);
    op(0, 0, 8'h80);
    chk("width", 8'h01, bus_width_select);
    host_port_strap_lo = 1;
    u_host.xfer(0, 0, 8'h08, q);
    host_port_strap_lo = 0;
    chk("ctl", 8'h07, display_ctl);
    host_port_strap_hi = 1;
    u_host.spi(0, 8'h0C);
    for (int i = 0; i < 99 && display_ctl !== 3'b100; i++) @(posedge core_clk);
    chk("ctl", 8'h04, display_ctl);
    chk("blank", 8'h00, scan_blank);
    end_sim();
  end
endmodule : char_lcd_instruction_engine_tb_top
`default_nettype wire
